/* common/vaio_defs.svh */
/*
  io port offsets, field positions, reset values and colour codes of the
  video adapter i/o front end; assumes inclusion by bare name
*/
`ifndef VAIO_DEFS_SVH
`define VAIO_DEFS_SVH
// decode: a9..a3 pattern for the timing controller window (a2,a1 ignored)
`define VAIO_CRTC_BASE   10'h3d0
`define VAIO_ADDR_INDEX  10'h3d4
`define VAIO_ADDR_DATA   10'h3d5
`define VAIO_ADDR_MODE   10'h3d8
`define VAIO_ADDR_COLSEL 10'h3d9
`define VAIO_ADDR_STATUS 10'h3da
`define VAIO_ADDR_PENCLR 10'h3db
`define VAIO_ADDR_PENSET 10'h3dc
// timing-controller register count and special indices
`define VAIO_CRTC_NREGS  5'h12
`define VAIO_IDX_CURS_H  5'h0e
`define VAIO_IDX_CURS_L  5'h0f
`define VAIO_IDX_PEN_H   5'h10
`define VAIO_IDX_PEN_L   5'h11
// colour-select fields
`define VAIO_CS_IRGB_MSB 3
`define VAIO_CS_INTSET   4
`define VAIO_CS_PALSET   5
// mode-control fields
`define VAIO_MC_HIRES80  0
`define VAIO_MC_GRAPH    1
`define VAIO_MC_HIRESBW  4
// status fields
`define VAIO_ST_SAFE     0
`define VAIO_ST_PENTRIG  1
`define VAIO_ST_PENSW    2
`define VAIO_ST_VRETR    3
// reset values
`define VAIO_RST_BYTE    8'h00
`define VAIO_RST_COLSEL  6'h00
`define VAIO_RST_INDEX   5'h00
// irgb colour codes, intensity low; intensity bit on its own
`define VAIO_GREEN   4'h2
`define VAIO_CYAN    4'h3
`define VAIO_RED     4'h4
`define VAIO_MAGENTA 4'h5
`define VAIO_BROWN   4'h6
`define VAIO_WHITE   4'h7
`define VAIO_INT_BIT 4'h8
`endif

/* common/vaio_pkg.sv */
/*
  types for the video adapter i/o front end; assumes vaio_defs.svh is
  available on the include path
*/
package vaio_pkg;
  // bus access phase state, one-hot
  typedef enum logic [3:0]
  {
    VAIO_IDLE  = 4'b0001,
    VAIO_WRITE = 4'b0010,
    VAIO_READ  = 4'b0100,
    VAIO_DONE  = 4'b1000
  } vaio_bus_e;
  typedef logic [3:0] vaio_irgb_t;
endpackage : vaio_pkg

/* core/vaio_regmem.sv */
/*
  eighteen-entry byte store of the timing-controller registers with a
  registered read port; assumes one clock and writes from the front end
*/
`timescale 1ns/1ps
`include "vaio_defs.svh"
module vaio_regmem
(
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rstn_i,
  // write port
  input  wire logic       we_i,
  input  wire logic [4:0] waddr_i,
  input  wire logic [7:0] wdata_i,
  // read port
  input  wire logic [4:0] raddr_i,
  output logic      [7:0] rdata_o
);
  // state as one struct
  typedef struct packed
  {
    logic [17:0][7:0] mem;   // register bytes
    logic [7:0]       rdata; // registered read data
  } vaio_mem_s;
  vaio_mem_s mem_reg;
  vaio_mem_s mem_next;

  // write decode and read mux
  always_comb
  begin
    mem_next = mem_reg;
    if (we_i && (waddr_i < `VAIO_CRTC_NREGS))
    begin
      mem_next.mem[waddr_i] = wdata_i;
    end
    // out-of-range index reads zero
    if (raddr_i < `VAIO_CRTC_NREGS)
    begin
      mem_next.rdata = mem_reg.mem[raddr_i];
    end
    else
    begin
      mem_next.rdata = `VAIO_RST_BYTE;
    end
  end

  // state register
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      mem_reg <= '0;
    end
    else
    begin
      mem_reg <= mem_next;
    end
  end

  assign rdata_o = mem_reg.rdata;
endmodule : vaio_regmem

/* core/vaio_top.sv */
/*
  i/o port decode, timing-controller index/data path, mode, colour-select,
  status and light-pen latch, plus two-bit pixel to irgb colour mapping.
  assumes a synchronous i/o strobe from host logic on CLK_I; pen, retrace
  and display-enable inputs are asynchronous and synchronised here.
*/
`timescale 1ns/1ps
`include "vaio_defs.svh"
module vaio_top
(
  // clock and reset
  input  wire logic       CLK_I,
  input  wire logic       RSTN_I,
  // host i/o bus
  input  wire logic [9:0] IO_ADDR_I,
  input  wire logic [7:0] IO_WDATA_I,
  input  wire logic       IO_WR_I,
  input  wire logic       IO_RD_I,
  output logic      [7:0] IO_RDATA_O,
  output logic            IO_RVALID_O,
  // raster and pen pins
  input  wire logic       DISP_SAFE_I,
  input  wire logic       VRETRACE_I,
  input  wire logic       PEN_TRIG_I,
  input  wire logic       PEN_SW_N_I,
  input  wire logic [7:0] PEN_ADDR_H_I,
  input  wire logic [7:0] PEN_ADDR_L_I,
  // pixel path
  input  wire logic       PIXEL_CODE_HIGH_I,
  input  wire logic       PIXEL_CODE_LOW_I,
  input  wire logic       BORDER_I,
  output logic      [3:0] COLOR_IRGB_O,
  // register views
  output logic      [7:0] MODE_CONTROL_O,
  output logic      [5:0] COLOR_SELECT_O,
  output logic            CRTC_WE_O,
  output logic      [4:0] CRTC_ADDR_O,
  output logic      [7:0] CRTC_WDATA_O
);
  // all state in one struct
  typedef struct packed
  {
    logic [1:0]         safe_s;    // display-safe synchroniser
    logic [1:0]         vret_s;    // retrace synchroniser
    logic [1:0]         pen_s;     // pen trigger synchroniser
    logic [1:0]         sw_s;      // pen switch synchroniser
    logic               pen_prev;  // pen level one cycle back
    logic               pen_flag;  // pen trigger latch
    logic [4:0]         index;     // controller index pointer
    logic [7:0]         mode;      // mode control
    logic [5:0]         colsel;    // colour select
    vaio_pkg::vaio_bus_e bus;      // access phase
    logic [1:0]         rsrc;      // read source for answer
    logic [7:0]         rdata;     // read data
    logic               rvalid;    // read answer strobe
    logic               crtc_we;   // controller write strobe
    logic [4:0]         crtc_addr; // controller write index
    logic [7:0]         crtc_wdata;// controller write data
    logic [3:0]         color;     // pixel colour out
  } vaio_st_s;
  vaio_st_s st_reg;
  vaio_st_s st_next;

  // read sources
  localparam logic [1:0] SRC_NONE = 2'h0;
  localparam logic [1:0] SRC_MEM  = 2'h1;
  localparam logic [1:0] SRC_PEN  = 2'h2;
  localparam logic [1:0] SRC_STAT = 2'h3;

  logic [7:0] mem_rdata;   // stored controller byte
  logic       mem_we;      // store write enable

  // timing-controller window decode, a2 and a1 ignored
  function automatic logic crtc_hit(input logic [9:0] a, input logic a0);
    crtc_hit = ((a & 10'h3f9) == (`VAIO_CRTC_BASE | {9'h000, a0}));
  endfunction : crtc_hit

  // palette mapping of a two-bit pixel code
  function automatic vaio_pkg::vaio_irgb_t pal_map(input logic [1:0] c,
                                                   input logic [5:0] cs);
    vaio_pkg::vaio_irgb_t base;
    base = `VAIO_GREEN;
    if (cs[`VAIO_CS_PALSET])
    begin
      case (c)
        2'h1:    base = `VAIO_CYAN;
        2'h2:    base = `VAIO_MAGENTA;
        default: base = `VAIO_WHITE;
      endcase
    end
    else
    begin
      case (c)
        2'h1:    base = `VAIO_GREEN;
        2'h2:    base = `VAIO_RED;
        default: base = `VAIO_BROWN;
      endcase
    end
    // bit 4 intensifies the foreground colours of either set
    if (cs[`VAIO_CS_INTSET])
    begin
      base = base | `VAIO_INT_BIT;
    end
    if (c == 2'h0)
    begin
      base = cs[`VAIO_CS_IRGB_MSB:0];
    end
    pal_map = base;
  endfunction : pal_map

  // controller register store
  vaio_regmem u_regmem
  (
    .clk_i   (CLK_I),
    .rstn_i  (RSTN_I),
    .we_i    (mem_we),
    .waddr_i (st_reg.index),
    .wdata_i (IO_WDATA_I),
    .raddr_i (st_reg.index),
    .rdata_o (mem_rdata)
  );

  // next-state logic
  always_comb
  begin
    logic [1:0] code;
    logic       graph;
    code    = {PIXEL_CODE_HIGH_I, PIXEL_CODE_LOW_I};
    graph   = 1'b0;
    st_next = st_reg;
    mem_we  = 1'b0;
    // pin synchronisers
    st_next.safe_s   = {st_reg.safe_s[0], DISP_SAFE_I};
    st_next.vret_s   = {st_reg.vret_s[0], VRETRACE_I};
    st_next.pen_s    = {st_reg.pen_s[0], PEN_TRIG_I};
    st_next.sw_s     = {st_reg.sw_s[0], PEN_SW_N_I};
    st_next.pen_prev = st_reg.pen_s[1];
    st_next.rvalid   = 1'b0;
    st_next.crtc_we  = 1'b0;
    // bus phase: one access per strobe, answer one cycle after
    case (st_reg.bus)
      vaio_pkg::VAIO_IDLE:
      begin
        if (IO_WR_I)
        begin
          st_next.bus = vaio_pkg::VAIO_WRITE;
          if (crtc_hit(IO_ADDR_I, 1'b0))
          begin
            st_next.index = IO_WDATA_I[4:0];
          end
          else if (crtc_hit(IO_ADDR_I, 1'b1))
          begin
            mem_we             = (st_reg.index < `VAIO_IDX_PEN_H);
            st_next.crtc_we    = mem_we;
            st_next.crtc_addr  = st_reg.index;
            st_next.crtc_wdata = IO_WDATA_I;
          end
          else if (IO_ADDR_I == `VAIO_ADDR_MODE)
          begin
            st_next.mode = IO_WDATA_I;
          end
          else if (IO_ADDR_I == `VAIO_ADDR_COLSEL)
          begin
            st_next.colsel = IO_WDATA_I[5:0];
          end
          else if (IO_ADDR_I == `VAIO_ADDR_PENCLR)
          begin
            st_next.pen_flag = 1'b0;
          end
          else if (IO_ADDR_I == `VAIO_ADDR_PENSET)
          begin
            st_next.pen_flag = 1'b1;
          end
          // other addresses: nothing stored
        end
        else if (IO_RD_I)
        begin
          st_next.bus  = vaio_pkg::VAIO_READ;
          st_next.rsrc = SRC_NONE;
          if (crtc_hit(IO_ADDR_I, 1'b1))
          begin
            if ((st_reg.index == `VAIO_IDX_CURS_H) || (st_reg.index == `VAIO_IDX_CURS_L))
            begin
              st_next.rsrc = SRC_MEM;
            end
            else if ((st_reg.index == `VAIO_IDX_PEN_H) ||
                     (st_reg.index == `VAIO_IDX_PEN_L))
            begin
              st_next.rsrc = SRC_PEN;
            end
          end
          else if (IO_ADDR_I == `VAIO_ADDR_STATUS)
          begin
            st_next.rsrc = SRC_STAT;
          end
          // write-only ports read zero, no side effect
        end
      end
      vaio_pkg::VAIO_READ:
      begin
        st_next.rvalid = 1'b1;
        st_next.bus    = vaio_pkg::VAIO_DONE;
        case (st_reg.rsrc)
          SRC_MEM:  st_next.rdata = mem_rdata;
          SRC_PEN:  st_next.rdata = (st_reg.index == `VAIO_IDX_PEN_H) ?
                                    PEN_ADDR_H_I : PEN_ADDR_L_I;
          SRC_STAT:
          begin
            st_next.rdata = `VAIO_RST_BYTE;
            st_next.rdata[`VAIO_ST_SAFE]    = st_reg.safe_s[1];
            st_next.rdata[`VAIO_ST_PENTRIG] = st_reg.pen_flag;
            st_next.rdata[`VAIO_ST_PENSW]   = st_reg.sw_s[1];
            st_next.rdata[`VAIO_ST_VRETR]   = st_reg.vret_s[1];
          end
          default:  st_next.rdata = `VAIO_RST_BYTE;
        endcase
      end
      vaio_pkg::VAIO_WRITE, vaio_pkg::VAIO_DONE:
      begin
        // wait for strobe release
        if (!IO_WR_I && !IO_RD_I)
        begin
          st_next.bus = vaio_pkg::VAIO_IDLE;
        end
      end
      default:
      begin
        st_next.bus = vaio_pkg::VAIO_IDLE;
      end
    endcase
    // pen rising edge sets the latch, winning over a clear
    if (st_reg.pen_s[1] && !st_reg.pen_prev)
    begin
      st_next.pen_flag = 1'b1;
    end
    // pixel colour by mode
    graph = st_reg.mode[`VAIO_MC_GRAPH];
    if (BORDER_I)
    begin
      st_next.color = st_reg.colsel[`VAIO_CS_IRGB_MSB:0];
    end
    else if (st_reg.mode[`VAIO_MC_HIRESBW])
    begin
      // one bit per dot, set dots take foreground
      st_next.color = PIXEL_CODE_LOW_I ?
                      st_reg.colsel[`VAIO_CS_IRGB_MSB:0] : 4'h0;
    end
    else if (graph)
    begin
      st_next.color = pal_map(code, st_reg.colsel);
    end
    else
    begin
      // text modes: code is fg/bg, bit 4 picks intensified bg
      st_next.color = code[0] ? `VAIO_WHITE :
                      (st_reg.colsel[`VAIO_CS_INTSET] ? `VAIO_INT_BIT : 4'h0);
    end
  end

  // state register
  always_ff @(posedge CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      st_reg        <= '0;
      st_reg.bus    <= vaio_pkg::VAIO_IDLE;
      st_reg.colsel <= `VAIO_RST_COLSEL;
      st_reg.index  <= `VAIO_RST_INDEX;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // outputs straight from flops
  assign IO_RDATA_O     = st_reg.rdata;
  assign IO_RVALID_O    = st_reg.rvalid;
  assign COLOR_IRGB_O   = st_reg.color;
  assign MODE_CONTROL_O = st_reg.mode;
  assign COLOR_SELECT_O = st_reg.colsel;
  assign CRTC_WE_O      = st_reg.crtc_we;
  assign CRTC_ADDR_O    = st_reg.crtc_addr;
  assign CRTC_WDATA_O   = st_reg.crtc_wdata;
endmodule : vaio_top

/* tb/vaio_checker_assertions.sv */
/* port assertions of vaio_top; bound into every vaio_top instance */
`timescale 1ns/1ps
`include "vaio_defs.svh"
module vaio_checker
(
  // watched ports
  input wire logic       CLK_I, RSTN_I, IO_WR_I, IO_RD_I, IO_RVALID_O, BORDER_I, CRTC_WE_O,
  input wire logic [9:0] IO_ADDR_I,
  input wire logic [7:0] IO_WDATA_I, IO_RDATA_O, MODE_CONTROL_O, CRTC_WDATA_O,
  input wire logic [5:0] COLOR_SELECT_O,
  input wire logic [4:0] CRTC_ADDR_O,
  input wire logic [3:0] COLOR_IRGB_O
);
  logic       wr_d, rd_d;                             // strobe history
  logic [4:0] idx;                                    // shadow index pointer
  wire wt = IO_WR_I & ~wr_d;                          // write taken
  wire rt = IO_RD_I & ~rd_d & ~IO_WR_I;               // read taken
  wire dp = (IO_ADDR_I & 10'h3f9) == 10'h3d1;         // data port, a2 a1 ignored
  wire am = IO_ADDR_I == `VAIO_ADDR_MODE;
  wire ac = IO_ADDR_I == `VAIO_ADDR_COLSEL;
  // shadow of the index, five low data bits
  always_ff @(posedge CLK_I or negedge RSTN_I)
    if (!RSTN_I)
      {wr_d, rd_d, idx} <= '0;
    else
    begin
      wr_d <= IO_WR_I;
      rd_d <= IO_RD_I;
      if (wt && (IO_ADDR_I & 10'h3f9) == `VAIO_CRTC_BASE)
        idx <= IO_WDATA_I[4:0];
    end
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RSTN_I);
  index_path_a:
    assert property (CRTC_WE_O |-> $past(wt && dp) && CRTC_ADDR_O == idx)
      else $error("controller write off index");
  data_store_a:
    assert property (wt && dp && idx < 5'h10 |=> CRTC_WE_O && CRTC_WDATA_O == $past(IO_WDATA_I))
      else $error("data port write lost");
  mode_load_a:
    assert property (wt && am |=> MODE_CONTROL_O == $past(IO_WDATA_I))
      else $error("mode not loaded");
  colsel_load_a:
    assert property (wt && ac |=> COLOR_SELECT_O == $past(IO_WDATA_I[5:0]))
      else $error("colour select not loaded");
  read_answer_a:
    assert property (rt |-> ##2 IO_RVALID_O ##1 !IO_RVALID_O)
      else $error("read answer misplaced");
  wo_read_a:
    assert property (rt && (am || ac) |-> ##2 IO_RDATA_O == 8'h00)
      else $error("write-only port read back");
  stray_write_a:
    assert property (wt && !am && !ac |=> $stable(COLOR_SELECT_O) && $stable(MODE_CONTROL_O))
      else $error("stray write changed a port");
  border_colour_a:
    assert property (BORDER_I |=> COLOR_IRGB_O == $past(COLOR_SELECT_O[3:0]))
      else $error("border colour wrong");
  // main scenarios reached
  cover property (CRTC_WE_O);
  cover property (rt && IO_ADDR_I == `VAIO_ADDR_STATUS);
  cover property (BORDER_I && COLOR_SELECT_O != 6'h00);
endmodule : vaio_checker
bind vaio_top vaio_checker i_vaio_checker
(
  .CLK_I, .RSTN_I, .IO_WR_I, .IO_RD_I, .IO_RVALID_O, .BORDER_I, .CRTC_WE_O, .IO_ADDR_I,
  .IO_WDATA_I, .IO_RDATA_O, .MODE_CONTROL_O, .CRTC_WDATA_O, .COLOR_SELECT_O, .CRTC_ADDR_O,
  .COLOR_IRGB_O
);

/* tb/vaio_host_model.sv */
/* host processor: i/o out and in cycles; callers enter at a falling edge */
`timescale 1ns/1ps
module vaio_host_model
(
  // clock and bus
  input  wire logic       clk_i,
  input  wire logic       rvalid_i,
  input  wire logic [7:0] rdata_i,
  output logic            wr_o,
  output logic            rd_o,
  output logic      [9:0] addr_o,
  output logic      [7:0] wdata_o
);
  // idle bus at time zero
  initial
  begin
    {wr_o, rd_o, addr_o, wdata_o} = '0;
  end
  // strobe held over one take edge, then released lines show inverted values
  task automatic drop;
    @(negedge clk_i);
    {wr_o, rd_o} = 2'b00;
    addr_o = ~addr_o;
    wdata_o = ~wdata_o;
    @(negedge clk_i);
  endtask : drop
  // out cycle
  task automatic io_out(input logic [9:0] a, input logic [7:0] v);
    addr_o = a;
    wdata_o = v;
    wr_o = 1'b1;
    drop();
  endtask : io_out
  // in cycle, answer awaited a bounded time
  task automatic io_in(input logic [9:0] a, output logic [7:0] v);
    addr_o = a;
    rd_o = 1'b1;
    drop();
    for (int n = 0; n < 6 && rvalid_i !== 1'b1; n++)
      @(negedge clk_i);
    v = (rvalid_i === 1'b1) ? rdata_i : 'x;
    // answer phase must close before the next strobe is taken
    @(negedge clk_i);
  endtask : io_in
endmodule : vaio_host_model

/* tb/testbench.sv */
/* self-checking bench of vaio_top; host bus from vaio_host_model, pins from here */
`timescale 1ns/1ps
`include "vaio_defs.svh"
module testbench;
  logic       clk, rst_n, io_wr, io_rd, io_rvalid, safe, vretr, trig, sw_n;
  logic       code_h, code_l, border, crtc_we;
  logic [9:0] io_addr;
  logic [7:0] io_wdata, io_rdata, pen_h, pen_l, mode_ctl, crtc_wdata, d;
  logic [5:0] colsel;
  logic [4:0] crtc_addr;
  logic [3:0] irgb;
  int         mismatches, checks_done, cycles;
  // device
  vaio_top i_vaio_top
  (
    .CLK_I(clk), .RSTN_I(rst_n), .IO_ADDR_I(io_addr), .IO_WDATA_I(io_wdata),
    .IO_WR_I(io_wr), .IO_RD_I(io_rd), .IO_RDATA_O(io_rdata), .IO_RVALID_O(io_rvalid),
    .DISP_SAFE_I(safe), .VRETRACE_I(vretr), .PEN_TRIG_I(trig), .PEN_SW_N_I(sw_n),
    .PEN_ADDR_H_I(pen_h), .PEN_ADDR_L_I(pen_l), .PIXEL_CODE_HIGH_I(code_h),
    .PIXEL_CODE_LOW_I(code_l), .BORDER_I(border), .COLOR_IRGB_O(irgb),
    .MODE_CONTROL_O(mode_ctl), .COLOR_SELECT_O(colsel), .CRTC_WE_O(crtc_we),
    .CRTC_ADDR_O(crtc_addr), .CRTC_WDATA_O(crtc_wdata)
  );
  // host
  vaio_host_model i_vaio_host_model
  (
    .clk_i(clk), .rvalid_i(io_rvalid), .rdata_i(io_rdata), .wr_o(io_wr), .rd_o(io_rd),
    .addr_o(io_addr), .wdata_o(io_wdata)
  );
  // 4 ns clock
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // hang guard
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      give_verdict();
    end
  end
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : give_verdict
  task automatic wr(input logic [9:0] a, input logic [7:0] v);
    i_vaio_host_model.io_out(a, v);
  endtask : wr
  task automatic rd(input logic [9:0] a);
    i_vaio_host_model.io_in(a, d);
  endtask : rd
  // status bits, pen latch set, clear and edge
  task automatic t_pen;
    safe = 1'b1;
    vretr = 1'b1;
    repeat (4) @(negedge clk);
    rd(`VAIO_ADDR_STATUS);
    check("status", d & 8'h0b, 8'h09);
    wr(`VAIO_ADDR_PENSET, 8'h00);
    rd(`VAIO_ADDR_STATUS);
    check("preset", d & 8'h0b, 8'h0b);
    wr(`VAIO_ADDR_STATUS, 8'h00);
    rd(`VAIO_ADDR_STATUS);
    check("ro status", d & 8'h0b, 8'h0b);
    wr(`VAIO_ADDR_PENCLR, 8'h5c);
    rd(`VAIO_ADDR_STATUS);
    check("clear", d & 8'h0b, 8'h09);
    trig = 1'b1;
    {safe, vretr} = 2'b00;
    repeat (4) @(negedge clk);
    trig = 1'b0;
    repeat (4) @(negedge clk);
    rd(`VAIO_ADDR_STATUS);
    check("pen edge", d & 8'h0b, 8'h02);
    $display("pen test done");
  endtask : t_pen
  // indexed path, aliases and access kinds
  task automatic t_crtc;
    wr(`VAIO_ADDR_INDEX, 8'h00);
    wr(`VAIO_ADDR_DATA, 8'h38);
    check("crtc addr", {3'h0, crtc_addr}, 8'h00);
    check("crtc data", crtc_wdata, 8'h38);
    rd(`VAIO_ADDR_DATA);
    check("wo entry", d, 8'h00);
    wr(`VAIO_ADDR_INDEX, 8'h0e);
    wr(`VAIO_ADDR_DATA, 8'h5a);
    wr(`VAIO_CRTC_BASE, 8'h0f);
    wr(10'h3d1, 8'ha5);
    rd(`VAIO_ADDR_DATA);
    check("cursor low", d, 8'ha5);
    wr(10'h3d2, 8'h0e);
    rd(10'h3d7);
    check("cursor high", d, 8'h5a);
    wr(`VAIO_ADDR_INDEX, 8'hf0);
    rd(`VAIO_ADDR_DATA);
    check("pen high", d, pen_h);
    wr(`VAIO_ADDR_INDEX, 8'h12);
    rd(`VAIO_ADDR_DATA);
    check("beyond", d, 8'h00);
    $display("crtc test done");
  endtask : t_crtc
  // plain ports and stray accesses
  task automatic t_ports;
    wr(`VAIO_ADDR_MODE, 8'h0a);
    wr(`VAIO_ADDR_COLSEL, 8'hff);
    rd(`VAIO_ADDR_COLSEL);
    check("colsel read", d, 8'h00);
    wr(10'h3de, 8'h00);
    check("mode", mode_ctl, 8'h0a);
    check("colsel", {2'h0, colsel}, 8'h3f);
    $display("port test done");
  endtask : t_ports
  // palette in 320 mode, then 640 foreground and border
  task automatic t_colour;
    logic [31:0] lut = {`VAIO_WHITE, `VAIO_MAGENTA, `VAIO_CYAN, 4'h9,
                        `VAIO_BROWN, `VAIO_RED, `VAIO_GREEN, 4'h9};
    logic [3:0]  e;
    for (int s = 0; s < 16; s++)
    begin
      wr(`VAIO_ADDR_COLSEL, {2'h0, s[3:2], 4'h9});
      {code_h, code_l} = s[1:0];
      @(negedge clk);
      e = lut[4 * {s[3], s[1:0]} +: 4];
      if (s[2] && s[1:0] != 2'b00)
        e = e | `VAIO_INT_BIT;
      check("palette", {4'h0, irgb}, {4'h0, e});
    end
    wr(`VAIO_ADDR_MODE, 8'h1a);
    check("fore 640", {4'h0, irgb}, 8'h09);
    code_l = 1'b0;
    @(negedge clk);
    check("back 640", {4'h0, irgb}, 8'h00);
    border = 1'b1;
    @(negedge clk);
    check("border", {4'h0, irgb}, 8'h09);
    border = 1'b0;
    wr(`VAIO_ADDR_MODE, 8'h00);
    check("text back", {4'h0, irgb}, 8'h08);
    code_l = 1'b1;
    @(negedge clk);
    check("text fore", {4'h0, irgb}, 8'h07);
    $display("colour test done");
  endtask : t_colour
  // main sequence
  initial
  begin
    {rst_n, safe, vretr, trig, code_h, code_l, border} = '0;
    sw_n = 1'b1;
    pen_h = 8'hc3;
    pen_l = 8'h3c;
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    t_pen();
    t_crtc();
    t_ports();
    t_colour();
    give_verdict();
  end
endmodule : testbench
